// >>> rtl/edp_pwm.sv
/*
 PWM unit: NGEN event-driven generators with dead-band, interrupt and
 ADC-trigger selection, buffered updates, counter sync, fault and stall
 handling, output gating and inversion, behind an Avalon-MM slave.
 Assumes FAULT and DBG_STALL are synchronous to CLK_SYS; NGEN is at most 3.
*/
// Summary of operation
// - Down mode runs load to zero and reloads; up/down climbs to load and back.
// - One-cycle pulses at zero and load; in down mode load follows zero.
// - A compare value above the load value never matches.
// - Down mode acts on zero, load, match A down, match B down.
// - Up/down mode acts on zero, load, and both matches in each direction.
// - Matches coinciding with zero or load are ignored by the outputs.
// - On a double match, output A uses only A, output B only B.
// - Each event per output may keep, toggle, drive low or drive high.
// - Dead-band off passes both generator outputs unchanged.
// - Dead-band on drops B; output A is input with delayed rise.
// - Dead-band output B is inverted input, rising late after input falls.
// - Any chosen event set raises the generator interrupt.
// - A separate chosen event set pulses the ADC trigger.
// - Interrupt and trigger use raw events, not dead-band edges.
// - Chosen counters are cleared together in one cycle.
// - Counter-reset bits clear the counter to zero and self-clear.
// - Immediate mode applies new load and compare at next zero.
// - Sync mode holds new values until global update, then next zero.
// - Update mode is chosen per generator for load and compare.
// - Each pin has a fault enable forcing it inactive on fault.
// - An active fault can raise an interrupt.
// - On stall a generator keeps running or runs to zero and halts.
// - A stall never raises an interrupt.
// - Each pin has an enable; all change in one register write.
// - Each pin may be inverted to active low.
`timescale 1ns/1ns
`include "edp_map.svh"
module edp_pwm
   import edp_pkg::*;
#(
   parameter int NGEN = 3
)
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input edp_avs_req_t AVS_REQ,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic FAULT,
   input wire logic DBG_STALL,
   output logic [2*NGEN-1:0] PWM_OUT,
   output logic [NGEN-1:0] GEN_INT,
   output logic [NGEN-1:0] ADC_TRIG,
   output logic FAULT_INT
);

   localparam int NP = 2 * NGEN;

   typedef struct packed {
      edp_gen_t [NGEN-1:0] g;
      logic [NP-1:0] out_en;
      logic [NP-1:0] inv;
      logic [NP-1:0] flt_en;
      logic flt_int_en;
      logic [NP-1:0] pins;
      logic flt_int;
      logic rd_ack;
      logic [31:0] rd_data;
   } edp_top_t;

   edp_top_t s_ff;
   edp_top_t nxt_s;
   logic [NP-1:0] db_sig;

   function automatic logic edp_in_page(input logic [7:0] addr, input int pg);
      return addr[7:6] == 2'(pg);
   endfunction : edp_in_page

   // Dead-band stages see registered generator outputs
   for (genvar i = 0; i < NGEN; i++) begin : g_db
      edp_deadband u_db (
         .clk_sys(CLK_SYS),
         .rst(RST),
         .cfg(s_ff.g[i].db),
         .in_a(s_ff.g[i].sa),
         .in_b(s_ff.g[i].sb),
         .out_a(db_sig[2*i]),
         .out_b(db_sig[2*i+1])
      );
      assign GEN_INT[i] = s_ff.g[i].irq;
      assign ADC_TRIG[i] = s_ff.g[i].trg;
   end

   always_comb begin
      logic [31:0] rv;
      logic [31:0] wv;
      logic [5:0] lo;
      logic wr;
      edp_gen_t gs;
      logic run;
      logic updn;
      logic adv;
      logic stop_now;
      logic z;
      logic l;
      logic ma;
      logic mb;
      logic mq;
      logic [`EDP_NEV-1:0] ev;
      logic [`EDP_NEV-1:0] ev_a;
      logic [`EDP_NEV-1:0] ev_b;
      logic va;
      logic vb;
      rv = 32'h0000_0000;
      wv = 32'h0000_0000;
      lo = AVS_REQ.address[5:0];
      wr = AVS_REQ.write;
      gs = s_ff.g[0];
      run = 1'b0;
      updn = 1'b0;
      adv = 1'b0;
      stop_now = 1'b0;
      z = 1'b0;
      l = 1'b0;
      ma = 1'b0;
      mb = 1'b0;
      mq = 1'b0;
      ev = '0;
      ev_a = '0;
      ev_b = '0;
      va = 1'b0;
      vb = 1'b0;
      nxt_s = s_ff;

      // Read mux; unmapped addresses read zero
      if (edp_in_page(AVS_REQ.address, 0)) begin
         case (lo)
            `EDP_R_UPD: begin
               for (int g = 0; g < NGEN; g++) begin
                  rv[g] = s_ff.g[g].gupd;
               end
            end
            `EDP_R_CSYNC: begin
               for (int g = 0; g < NGEN; g++) begin
                  rv[g] = s_ff.g[g].csync;
               end
            end
            `EDP_R_ENABLE: rv[NP-1:0] = s_ff.out_en;
            `EDP_R_INVERT: rv[NP-1:0] = s_ff.inv;
            `EDP_R_FAULT: rv[NP-1:0] = s_ff.flt_en;
            `EDP_R_FINTEN: rv[0] = s_ff.flt_int_en;
            `EDP_R_STATUS: begin
               rv[`EDP_STAT_FAULT] = FAULT;
               for (int g = 0; g < NGEN; g++) begin
                  rv[g] = s_ff.g[g].halt;
                  rv[`EDP_STAT_DIR + g] = s_ff.g[g].dir;
               end
            end
            default: rv = 32'h0000_0000;
         endcase
      end
      for (int g = 0; g < NGEN; g++) begin
         if (edp_in_page(AVS_REQ.address, g + 1)) begin
            gs = s_ff.g[g];
            case (lo)
               `EDP_G_CTL: rv[`EDP_CTL_W-1:0] = gs.ctl;
               `EDP_G_EVEN: rv = {16'h0000, 2'b00, gs.trg_en, 2'b00, gs.int_en};
               `EDP_G_LOAD: rv[`EDP_CW-1:0] = gs.ld_sh;
               `EDP_G_COUNT: rv[`EDP_CW-1:0] = gs.cnt;
               `EDP_G_CMPA: rv[`EDP_CW-1:0] = gs.ca_sh;
               `EDP_G_CMPB: rv[`EDP_CW-1:0] = gs.cb_sh;
               `EDP_G_ACTA: rv[2*`EDP_NEV-1:0] = gs.act_a;
               `EDP_G_ACTB: rv[2*`EDP_NEV-1:0] = gs.act_b;
               `EDP_G_DBCTL: rv[0] = gs.db.en;
               `EDP_G_DBRISE: rv[`EDP_DW-1:0] = gs.db.rise;
               `EDP_G_DBFALL: rv[`EDP_DW-1:0] = gs.db.fall;
               default: rv = 32'h0000_0000;
            endcase
         end
      end
      wv = edp_merge(rv, AVS_REQ.writedata, AVS_REQ.byteenable);

      // One wait state on reads so read data come from a flip-flop
      nxt_s.rd_ack = AVS_REQ.read && !s_ff.rd_ack;
      if (AVS_REQ.read && !s_ff.rd_ack) begin
         nxt_s.rd_data = rv;
      end

      // Generators
      for (int g = 0; g < NGEN; g++) begin
         gs = s_ff.g[g];
         run = gs.ctl[`EDP_CTL_RUN];
         updn = gs.ctl[`EDP_CTL_MODE];
         adv = run && !gs.halt;
         z = adv && (gs.cnt == '0);
         l = adv && (gs.cnt == gs.ld);
         ma = adv && (gs.cnt == gs.ca) && (gs.ca <= gs.ld);
         mb = adv && (gs.cnt == gs.cb) && (gs.cb <= gs.ld);
         mq = !(z || l);
         ev[`EDP_EV_ZERO] = z;
         ev[`EDP_EV_LOAD] = l;
         // Direction is always down in down mode, so the up events stay idle
         ev[`EDP_EV_AUP] = ma && mq && gs.dir;
         ev[`EDP_EV_ADN] = ma && mq && !gs.dir;
         ev[`EDP_EV_BUP] = mb && mq && gs.dir;
         ev[`EDP_EV_BDN] = mb && mq && !gs.dir;
         ev_a = ev;
         ev_b = ev;
         if (ma && mb) begin
            ev_a[`EDP_EV_BDN:`EDP_EV_BUP] = 2'b00;
            ev_b[`EDP_EV_ADN:`EDP_EV_AUP] = 2'b00;
         end
         va = gs.sa;
         vb = gs.sb;
         // Later events in the list win when several land in one cycle
         for (int e = 0; e < `EDP_NEV; e++) begin
            if (ev_a[e]) begin
               va = edp_apply(va, edp_act_t'(gs.act_a[2*e +: 2]));
            end
            if (ev_b[e]) begin
               vb = edp_apply(vb, edp_act_t'(gs.act_b[2*e +: 2]));
            end
         end
         nxt_s.g[g].sa = va;
         nxt_s.g[g].sb = vb;
         // Raw events only; stall and dead-band have no say here
         nxt_s.g[g].irq = |(ev & gs.int_en);
         nxt_s.g[g].trg = |(ev & gs.trg_en);

         // Buffered updates land at zero
         if (z) begin
            if (!gs.ctl[`EDP_CTL_LDSYNC] || gs.gupd) begin
               nxt_s.g[g].ld = gs.ld_sh;
            end
            if (!gs.ctl[`EDP_CTL_CMPSYNC] || gs.gupd) begin
               nxt_s.g[g].ca = gs.ca_sh;
               nxt_s.g[g].cb = gs.cb_sh;
            end
            nxt_s.g[g].gupd = 1'b0;
         end

         // Counter; halting on stall keeps it parked at zero
         stop_now = z && DBG_STALL && gs.ctl[`EDP_CTL_STALL];
         if (gs.halt) begin
            nxt_s.g[g].halt = DBG_STALL && run;
         end else begin
            nxt_s.g[g].halt = stop_now;
         end
         if (adv && !stop_now) begin
            if (!updn) begin
               nxt_s.g[g].dir = 1'b0;
               if (gs.cnt == '0) begin
                  nxt_s.g[g].cnt = nxt_s.g[g].ld;
               end else begin
                  nxt_s.g[g].cnt = `EDP_CW'(gs.cnt - 1'b1);
               end
            end else if (gs.dir) begin
               if (gs.cnt >= gs.ld) begin
                  nxt_s.g[g].dir = 1'b0;
                  nxt_s.g[g].cnt = (gs.cnt == '0) ? gs.cnt : `EDP_CW'(gs.cnt - 1'b1);
               end else begin
                  nxt_s.g[g].cnt = `EDP_CW'(gs.cnt + 1'b1);
               end
            end else begin
               if (gs.cnt == '0) begin
                  nxt_s.g[g].dir = 1'b1;
                  nxt_s.g[g].cnt = (nxt_s.g[g].ld == '0) ? gs.cnt : `EDP_CW'(1);
               end else begin
                  nxt_s.g[g].cnt = `EDP_CW'(gs.cnt - 1'b1);
               end
            end
         end
         if (gs.csync) begin
            nxt_s.g[g].cnt = '0;
            nxt_s.g[g].dir = updn;
            nxt_s.g[g].csync = 1'b0;
         end

         // Register writes come last so a set beats a same-cycle clear
         if (wr && edp_in_page(AVS_REQ.address, 0)) begin
            if (lo == `EDP_R_UPD && wv[g]) begin
               nxt_s.g[g].gupd = 1'b1;
            end
            if (lo == `EDP_R_CSYNC && wv[g]) begin
               nxt_s.g[g].csync = 1'b1;
            end
         end
         if (wr && edp_in_page(AVS_REQ.address, g + 1)) begin
            case (lo)
               `EDP_G_CTL: nxt_s.g[g].ctl = wv[`EDP_CTL_W-1:0];
               `EDP_G_EVEN: begin
                  nxt_s.g[g].int_en = wv[`EDP_NEV-1:0];
                  nxt_s.g[g].trg_en = wv[`EDP_TRG_LSB +: `EDP_NEV];
               end
               `EDP_G_LOAD: nxt_s.g[g].ld_sh = wv[`EDP_CW-1:0];
               `EDP_G_CMPA: nxt_s.g[g].ca_sh = wv[`EDP_CW-1:0];
               `EDP_G_CMPB: nxt_s.g[g].cb_sh = wv[`EDP_CW-1:0];
               `EDP_G_ACTA: nxt_s.g[g].act_a = wv[2*`EDP_NEV-1:0];
               `EDP_G_ACTB: nxt_s.g[g].act_b = wv[2*`EDP_NEV-1:0];
               `EDP_G_DBCTL: nxt_s.g[g].db.en = wv[0];
               `EDP_G_DBRISE: nxt_s.g[g].db.rise = wv[`EDP_DW-1:0];
               `EDP_G_DBFALL: nxt_s.g[g].db.fall = wv[`EDP_DW-1:0];
               default: nxt_s.g[g].ctl = gs.ctl;
            endcase
         end
      end

      // Global control writes
      if (wr && edp_in_page(AVS_REQ.address, 0)) begin
         case (lo)
            `EDP_R_ENABLE: nxt_s.out_en = wv[NP-1:0];
            `EDP_R_INVERT: nxt_s.inv = wv[NP-1:0];
            `EDP_R_FAULT: nxt_s.flt_en = wv[NP-1:0];
            `EDP_R_FINTEN: nxt_s.flt_int_en = wv[0];
            default: nxt_s.flt_int_en = s_ff.flt_int_en;
         endcase
      end

      // Output stage: fault forces the inactive level ahead of inversion
      for (int i = 0; i < NP; i++) begin
         nxt_s.pins[i] = (s_ff.out_en[i] && !(FAULT && s_ff.flt_en[i]) && db_sig[i])
                         ^ s_ff.inv[i];
      end
      nxt_s.flt_int = FAULT && s_ff.flt_int_en;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         s_ff <= `EDP_RST_STATE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign AVS_WAITREQUEST = AVS_REQ.read && !s_ff.rd_ack;
   assign AVS_READDATA = s_ff.rd_data;
   assign PWM_OUT = s_ff.pins;
   assign FAULT_INT = s_ff.flt_int;

endmodule : edp_pwm

// >>> inc/edp_map.svh
/*
 Address map, field positions, widths and reset pattern of the PWM unit.
 Assumes byte addresses on an 8-bit Avalon-MM address; bits 7:6 pick the page.
*/
`ifndef EDP_MAP_SVH
`define EDP_MAP_SVH

`define EDP_CW 16
`define EDP_DW 12
`define EDP_NEV 6
`define EDP_RST_STATE '0

// Global page (address bits 7:6 = 0)
`define EDP_R_UPD 6'h00
`define EDP_R_CSYNC 6'h04
`define EDP_R_ENABLE 6'h08
`define EDP_R_INVERT 6'h0C
`define EDP_R_FAULT 6'h10
`define EDP_R_FINTEN 6'h14
`define EDP_R_STATUS 6'h18

// Generator page g sits at (g+1)*0x40
`define EDP_G_CTL 6'h00
`define EDP_G_EVEN 6'h04
`define EDP_G_LOAD 6'h08
`define EDP_G_COUNT 6'h0C
`define EDP_G_CMPA 6'h10
`define EDP_G_CMPB 6'h14
`define EDP_G_ACTA 6'h18
`define EDP_G_ACTB 6'h1C
`define EDP_G_DBCTL 6'h20
`define EDP_G_DBRISE 6'h24
`define EDP_G_DBFALL 6'h28

`define EDP_CTL_RUN 0
`define EDP_CTL_MODE 1
`define EDP_CTL_STALL 2
`define EDP_CTL_LDSYNC 3
`define EDP_CTL_CMPSYNC 4
`define EDP_CTL_W 5

`define EDP_EV_ZERO 0
`define EDP_EV_LOAD 1
`define EDP_EV_AUP 2
`define EDP_EV_ADN 3
`define EDP_EV_BUP 4
`define EDP_EV_BDN 5
`define EDP_TRG_LSB 8
`define EDP_STAT_FAULT 8
`define EDP_STAT_DIR 16

`endif

// >>> inc/edp_pkg.sv
/*
 Types and small helpers shared by the PWM unit.
 Assumes edp_map.svh is on the include path.
*/
`include "edp_map.svh"
package edp_pkg;

   typedef enum logic [1:0] {
      EDP_ACT_KEEP = 2'b00,
      EDP_ACT_TOGGLE = 2'b01,
      EDP_ACT_LOW = 2'b10,
      EDP_ACT_HIGH = 2'b11
   } edp_act_t;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } edp_avs_req_t;

   typedef struct packed {
      logic en;
      logic [`EDP_DW-1:0] rise;
      logic [`EDP_DW-1:0] fall;
   } edp_db_cfg_t;

   typedef struct packed {
      logic [`EDP_DW-1:0] hi_cnt;
      logic [`EDP_DW-1:0] lo_cnt;
      logic out_a;
      logic out_b;
   } edp_db_t;

   typedef struct packed {
      logic [`EDP_CW-1:0] cnt;
      logic dir;
      logic halt;
      logic [`EDP_CW-1:0] ld;
      logic [`EDP_CW-1:0] ld_sh;
      logic [`EDP_CW-1:0] ca;
      logic [`EDP_CW-1:0] ca_sh;
      logic [`EDP_CW-1:0] cb;
      logic [`EDP_CW-1:0] cb_sh;
      logic [`EDP_CTL_W-1:0] ctl;
      logic [`EDP_NEV-1:0] int_en;
      logic [`EDP_NEV-1:0] trg_en;
      logic [2*`EDP_NEV-1:0] act_a;
      logic [2*`EDP_NEV-1:0] act_b;
      edp_db_cfg_t db;
      logic sa;
      logic sb;
      logic gupd;
      logic csync;
      logic irq;
      logic trg;
   } edp_gen_t;

   function automatic logic edp_apply(input logic cur, input edp_act_t act);
      logic r;
      r = cur;
      unique case (act)
         EDP_ACT_KEEP: r = cur;
         EDP_ACT_TOGGLE: r = ~cur;
         EDP_ACT_LOW: r = 1'b0;
         EDP_ACT_HIGH: r = 1'b1;
      endcase
      return r;
   endfunction : edp_apply

   function automatic logic [31:0] edp_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : edp_merge

endpackage : edp_pkg

// >>> rtl/edp_deadband.sv
/*
 Dead-band stage of one generator: bypass or complementary pair with
 separate rising-edge delays, in clock cycles.
 Assumes inputs come from flip-flops on the same clock.
*/
`timescale 1ns/1ns
`include "edp_map.svh"
module edp_deadband
   import edp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input edp_db_cfg_t cfg,
   input wire logic in_a,
   input wire logic in_b,
   output logic out_a,
   output logic out_b
);

   edp_db_t s_ff;
   edp_db_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      // Counters saturate so a long steady level never wraps into a false edge
      if (in_a) begin
         nxt_s.hi_cnt = (s_ff.hi_cnt == '1) ? s_ff.hi_cnt : `EDP_DW'(s_ff.hi_cnt + 1'b1);
         nxt_s.lo_cnt = '0;
      end else begin
         nxt_s.lo_cnt = (s_ff.lo_cnt == '1) ? s_ff.lo_cnt : `EDP_DW'(s_ff.lo_cnt + 1'b1);
         nxt_s.hi_cnt = '0;
      end
      if (cfg.en) begin
         nxt_s.out_a = in_a && (s_ff.hi_cnt >= cfg.rise);
         nxt_s.out_b = !in_a && (s_ff.lo_cnt >= cfg.fall);
      end else begin
         nxt_s.out_a = in_a;
         nxt_s.out_b = in_b;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_ff <= `EDP_RST_STATE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign out_a = s_ff.out_a;
   assign out_b = s_ff.out_b;

endmodule : edp_deadband

// >>> verif/edp_pwm_props.sv
/*
 Port-level checker for edp_pwm, with register shadows rebuilt from bus writes.
 Assumes writes use all four byte lanes and word-aligned addresses.
*/
`timescale 1ns/1ns
module edp_pwm_props
   import edp_pkg::*;
#(
   parameter int NGEN = 3
)
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input edp_avs_req_t AVS_REQ,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic FAULT,
   input wire logic DBG_STALL,
   input wire logic [2*NGEN-1:0] PWM_OUT,
   input wire logic [NGEN-1:0] GEN_INT,
   input wire logic [NGEN-1:0] ADC_TRIG,
   input wire logic FAULT_INT
);
   logic [2*NGEN-1:0] en_ff, inv_ff, fen_ff, lvl;
   logic [NGEN-1:0] ien_ff, ten_ff, db_ff, both;
   logic fint_ff, fint_src;
   logic [2:0] quiet_ff;
   logic [7:0] adr;
   logic [31:0] wd;
   assign adr = AVS_REQ.address;
   assign wd = AVS_REQ.writedata;
   assign lvl = PWM_OUT ^ inv_ff;
   assign fint_src = FAULT && fint_ff;
   always_comb begin
      for (int g = 0; g < NGEN; g++) begin
         both[g] = lvl[2*g] & lvl[2*g+1];
      end
   end
   // Quiet count lets pipelined outputs catch up after any write
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         {en_ff, inv_ff, fen_ff, ien_ff, ten_ff, db_ff, fint_ff} <= '0;
         quiet_ff <= 3'h0;
      end else if (AVS_REQ.write) begin
         quiet_ff <= 3'h0;
         case (adr)
            8'h08: en_ff <= wd[2*NGEN-1:0];
            8'h0C: inv_ff <= wd[2*NGEN-1:0];
            8'h10: fen_ff <= wd[2*NGEN-1:0];
            8'h14: fint_ff <= wd[0];
            default: ;
         endcase
         for (int g = 0; g < NGEN; g++) begin
            if (adr[7:6] == 2'(g + 1) && adr[5:2] == 4'h1) begin
               ien_ff[g] <= |wd[5:0];
               ten_ff[g] <= |wd[13:8];
            end
            if (adr[7:6] == 2'(g + 1) && adr[5:2] == 4'h8) begin
               db_ff[g] <= wd[0];
            end
         end
      end else if (quiet_ff != 3'h7) begin
         quiet_ff <= quiet_ff + 3'h1;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   property p_gate; quiet_ff >= 3'h3 |-> (lvl & ~en_ff) == '0; endproperty
   a_gate: assert property (p_gate)
      else $error("disabled pin not at its idle level");
   property p_fault; (FAULT && quiet_ff >= 3'h3) [*3] |-> (lvl & fen_ff) == '0; endproperty
   a_fault: assert property (p_fault)
      else $error("fault-enabled pin still active under fault");
   property p_fint; FAULT_INT == $past(fint_src); endproperty
   a_fint: assert property (p_fint)
      else $error("fault interrupt does not follow the fault input");
   property p_stall; DBG_STALL && !FAULT && !$past(FAULT) |-> !FAULT_INT; endproperty
   a_stall: assert property (p_stall)
      else $error("interrupt raised by stall");
   property p_int_off; quiet_ff >= 3'h3 |-> (GEN_INT & ~ien_ff) == '0; endproperty
   a_int_off: assert property (p_int_off)
      else $error("generator interrupt with no event selected");
   property p_trg_off; quiet_ff >= 3'h3 |-> (ADC_TRIG & ~ten_ff) == '0; endproperty
   a_trg_off: assert property (p_trg_off)
      else $error("converter trigger with no event selected");
   property p_db; quiet_ff >= 3'h4 |-> (both & db_ff) == '0; endproperty
   a_db: assert property (p_db)
      else $error("complementary pair both active");
   property p_rd; $rose(AVS_REQ.read) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endproperty
   a_rd: assert property (p_rd)
      else $error("read answer not after one wait cycle");
   property p_wr; AVS_REQ.write |-> !AVS_WAITREQUEST; endproperty
   a_wr: assert property (p_wr)
      else $error("write stalled");
   c_fint: cover property (FAULT_INT);
   c_trg: cover property (ADC_TRIG != '0);
   c_db: cover property (db_ff != '0 && quiet_ff == 3'h7);
endmodule : edp_pwm_props

bind edp_pwm edp_pwm_props #(.NGEN(NGEN)) u_props (.CLK_SYS(CLK_SYS), .RST(RST),
   .AVS_REQ(AVS_REQ), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .FAULT(FAULT), .DBG_STALL(DBG_STALL), .PWM_OUT(PWM_OUT), .GEN_INT(GEN_INT),
   .ADC_TRIG(ADC_TRIG), .FAULT_INT(FAULT_INT));

// >>> verif/edp_leg_model.sv
/*
 Gate-driver input of one half-bridge leg: counts shoot-through cycles.
 Assumes both gate commands are active high on the clock of the unit.
*/
`timescale 1ns/1ns
module edp_leg_model (
   input wire logic clk,
   input wire logic gate_hi,
   input wire logic gate_lo,
   output logic [15:0] shoot_cnt
);
   logic [15:0] shoot_ff = 16'h0000;
   assign shoot_cnt = shoot_ff;
   // Both switches on shorts the supply rail
   always @(posedge clk) begin
      if (gate_hi && gate_lo) begin
         shoot_ff <= shoot_ff + 16'h0001;
      end
   end
endmodule : edp_leg_model

// >>> verif/test_edp_pwm.sv
/*
 Self-checking bench for edp_pwm: register tasks, waveform counts, fault and stall.
 Assumes the checker is bound and the leg model watches generator 2.
*/
`timescale 1ns/1ns
module test_edp_pwm
   import edp_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic fault = 1'b0;
   logic stall = 1'b0;
   edp_avs_req_t req = '0;
   logic [31:0] rdata;
   logic wq, fint;
   logic [5:0] pwm;
   logic [2:0] gint, trg;
   logic [15:0] shoot;
   wire logic [11:0] mon = {trg, gint, pwm};
   int failures = 0;
   int checks = 0;
   always #20 clk_sys = ~clk_sys;
   edp_pwm #(.NGEN(3)) dut (.CLK_SYS(clk_sys), .RST(rst), .AVS_REQ(req), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wq), .FAULT(fault), .DBG_STALL(stall), .PWM_OUT(pwm), .GEN_INT(gint),
      .ADC_TRIG(trg), .FAULT_INT(fint));
   edp_leg_model leg (.clk(clk_sys), .gate_hi(pwm[4]), .gate_lo(pwm[5]), .shoot_cnt(shoot));
   task automatic end_sim;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int k = 0;
      req <= '{a, rd, !rd, d, 4'hF};
      do begin
         @(posedge clk_sys);
         k++;
      end while (wq !== 1'b0);
      q = rdata;
      req <= '0;
      @(posedge clk_sys);
      // Reads carry exactly one wait state, writes none
      chk(32'(k), rd ? 32'h2 : 32'h1);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b0, a, d, q);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] q;
      xfer(1'b1, a, 32'h0, q);
      chk(q & m, exp);
   endtask : rd_chk
   // Negative exp: output must stay constant over the window
   task automatic cnt(input int sel, input int exp);
      int n = 0;
      repeat (20) begin
         @(posedge clk_sys);
         n += (mon[sel] === 1'b1);
      end
      chk(32'(exp < 0 ? (n % 20 == 0) : n), 32'(exp < 0 ? 1 : exp));
   endtask : cnt
   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      end_sim();
   end
   initial begin
      logic [39:0] cfg [17] = '{40'h4800000009, 40'h5000000004, 40'h5400000004,
         40'h5800000083, 40'h5C000000C2, 40'h4400000209, 40'h8800000005, 40'h9000000002,
         40'h98000000B0, 40'hC800000009, 40'hD000000004, 40'hD800000083, 40'hDC00000CC2,
         40'h080000003F, 40'h4000000001, 40'h8000000003, 40'hC000000001};
      int db [2][4] = '{'{2, 3, 8, 2}, '{0, 0, 12, 8}};
      logic [15:0] s0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd_chk(8'h08, 32'h0, 32'hFFFFFFFF);
      wr(8'h1C, 32'hFFFF);
      rd_chk(8'h1C, 32'h0, 32'hFFFFFFFF);
      wr(8'hCC, 32'h55);
      rd_chk(8'hCC, 32'h0, 32'hFFFFFFFF);
      done("map");
      foreach (cfg[i]) wr(cfg[i][39:32], cfg[i][31:0]);
      repeat (30) @(posedge clk_sys);
      cnt(0, 12);
      cnt(1, 0);
      cnt(2, 12);
      cnt(6, 4);
      cnt(9, 2);
      cnt(4, 12);
      cnt(5, 8);
      wr(8'h90, 32'h6);
      repeat (30) @(posedge clk_sys);
      cnt(2, -1);
      done("generate");
      wr(8'h40, 32'h9);
      wr(8'h48, 32'h13);
      repeat (40) @(posedge clk_sys);
      cnt(0, 12);
      wr(8'h00, 32'h1);
      repeat (50) @(posedge clk_sys);
      cnt(0, 16);
      rd_chk(8'h00, 32'h0, 32'h1);
      done("update");
      wr(8'hE0, 32'h1);
      foreach (db[i]) begin
         wr(8'hE4, 32'(db[i][0]));
         wr(8'hE8, 32'(db[i][1]));
         repeat (20) @(posedge clk_sys);
         s0 = shoot;
         cnt(4, db[i][2]);
         cnt(5, db[i][3]);
         chk(32'(shoot - s0), 32'h0);
      end
      done("deadband");
      wr(8'h10, 32'h1);
      wr(8'h14, 32'h1);
      wr(8'h0C, 32'h2);
      fault <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk(32'(pwm[1:0]), 32'h2);
      chk(32'(fint), 32'h1);
      wr(8'h08, 32'h0);
      repeat (5) @(posedge clk_sys);
      chk(32'(pwm), 32'h2);
      fault <= 1'b0;
      done("fault");
      wr(8'h40, 32'h0);
      wr(8'h80, 32'h0);
      wr(8'h04, 32'h3);
      repeat (3) @(posedge clk_sys);
      rd_chk(8'h4C, 32'h0, 32'hFFFFFFFF);
      rd_chk(8'h8C, 32'h0, 32'hFFFFFFFF);
      rd_chk(8'h04, 32'h0, 32'hFFFFFFFF);
      done("sync");
      wr(8'h80, 32'h7);
      repeat (3) @(posedge clk_sys);
      stall <= 1'b1;
      repeat (40) @(posedge clk_sys);
      rd_chk(8'h18, 32'h2, 32'h2);
      rd_chk(8'h8C, 32'h0, 32'hFFFFFFFF);
      chk(32'(fint), 32'h0);
      stall <= 1'b0;
      done("stall");
      end_sim();
   end
endmodule : test_edp_pwm
